// ===== hw/quad_phy_mgmt_serial_port.sv
module quad_phy_mgmt_serial_port
  import mgmt_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [2:0] chip_address_straps
);

  // Reset release pipeline
  logic [1:0] rst_pipe;
  wire        rst_n;

  // Synchronised pins
  wire  [SYNC_WIDTH-1:0] pin_raw;
  logic [SYNC_WIDTH-1:0] pin_sync;
  wire                   mdc_level;
  wire                   mdio_level;
  wire  [2:0]            strap_level;

  // Strap capture
  logic [3:0] strap_count;
  logic       straps_ready;
  logic [2:0] chip_addr;

  // Clock edge detection
  logic mdc_prev;
  wire  mdc_rise;

  // Frame decoder state
  frame_state_t state;
  frame_state_t next_state;
  logic [4:0]   bit_cnt;
  logic [4:0]   next_bit_cnt;
  logic [15:0]  rx_shift;
  wire  [15:0]  shifted;
  logic         is_read;
  logic         next_is_read;
  logic [1:0]   channel;
  logic [1:0]   next_channel;
  logic [4:0]   reg_addr;
  logic [4:0]   next_reg_addr;
  logic         next_rd_en;
  logic         next_wr_en;

  // Address decode
  wire        addr_broadcast;
  wire        addr_local;
  wire        addr_match;
  wire [1:0]  op_code;
  wire        op_valid;

  // Read drive path
  logic [15:0] tx_shift;
  wire         ta_first_end;
  wire         ta_second_end;
  wire         data_bit_end;
  wire         data_last_end;

  mgmt_bank_if bank_bus ();

  // Release reset synchronously to the core clock
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_n = rst_pipe[1];

  // Clock, data and straps arrive from outside the core clock domain
  assign pin_raw = {chip_address_straps, mdio_in, mdc};

  mgmt_input_sync #(
    .WIDTH (SYNC_WIDTH)
  ) pin_sync_inst (
    .clk      (core_clk),
    .rst_n    (rst_n),
    .async_in (pin_raw),
    .sync_out (pin_sync)
  );

  assign mdc_level   = pin_sync[0];
  assign mdio_level  = pin_sync[1];
  assign strap_level = pin_sync[4:2];

  // Latch straps once the pipeline has settled after reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_count  <= 4'h0;
      straps_ready <= 1'b0;
      chip_addr    <= 3'h0;
    end
    else if (!straps_ready)
    begin
      strap_count <= strap_count + 4'h1;
      if (strap_count == STRAP_SETTLE_CYCLES)
      begin
        straps_ready <= 1'b1;
        chip_addr    <= strap_level;
      end
    end
  end

  // Rising management clock edges, held off until straps are known
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      mdc_prev <= 1'b0;
    else
      mdc_prev <= mdc_level;
  end

  assign mdc_rise = mdc_level && !mdc_prev && straps_ready; // [RULE_18]

  // Field decode from the bits collected so far
  assign shifted        = {rx_shift[14:0], mdio_level}; // [RULE_18]
  assign op_code        = shifted[1:0];
  assign op_valid       = (op_code == OP_READ) || (op_code == OP_WRITE); // [RULE_05]
  assign addr_broadcast = (shifted[4:0] == BROADCAST_ADDR); // [RULE_07]
  assign addr_local     = (shifted[4:2] == chip_addr); // [RULE_08]
  assign addr_match     = addr_broadcast || addr_local;

  // Frame walk, advanced once per management clock rise
  always_comb
  begin
    next_state    = state;
    next_bit_cnt  = bit_cnt;
    next_is_read  = is_read;
    next_channel  = channel;
    next_reg_addr = reg_addr;
    next_rd_en    = 1'b0;
    next_wr_en    = 1'b0;
    if (mdc_rise)
    begin
      case (state)
        FRAME_HUNT:
        begin
          // Preamble ones are skipped; the first zero opens the start pattern
          if (!mdio_level)
            next_state = FRAME_START; // [RULE_02] [RULE_03]
        end
        FRAME_START:
        begin
          // Zero then one; further zeros keep waiting for the one
          if (mdio_level)
          begin
            next_state   = FRAME_OP; // [RULE_04]
            next_bit_cnt = 5'h00;
          end
        end
        FRAME_OP:
        begin
          if (bit_cnt == OP_LAST)
          begin
            next_bit_cnt = 5'h00;
            next_is_read = (op_code == OP_READ); // [RULE_05]
            if (op_valid)
              next_state = FRAME_PHYAD;
            else
            begin
              next_state   = FRAME_SKIP;
              next_bit_cnt = SKIP_AFTER_OP;
            end
          end
          else
            next_bit_cnt = bit_cnt + 5'h01;
        end
        FRAME_PHYAD:
        begin
          if (bit_cnt == ADDR_LAST)
          begin
            next_channel = shifted[1:0]; // [RULE_06] [RULE_09]
            if (addr_match)
            begin
              next_state   = FRAME_REGAD;
              next_bit_cnt = 5'h00;
            end
            else
            begin
              next_state   = FRAME_SKIP; // [RULE_19]
              next_bit_cnt = SKIP_AFTER_PHY;
            end
          end
          else
            next_bit_cnt = bit_cnt + 5'h01;
        end
        FRAME_REGAD:
        begin
          if (bit_cnt == ADDR_LAST)
          begin
            next_reg_addr = shifted[4:0]; // [RULE_10]
            next_rd_en    = is_read;
            next_state    = FRAME_TA;
            next_bit_cnt  = 5'h00;
          end
          else
            next_bit_cnt = bit_cnt + 5'h01;
        end
        FRAME_TA:
        begin
          // Write turnaround bits are taken as sent and not checked
          if (bit_cnt == TA_LAST)
          begin
            next_state   = FRAME_DATA; // [RULE_11]
            next_bit_cnt = 5'h00;
          end
          else
            next_bit_cnt = bit_cnt + 5'h01;
        end
        FRAME_DATA:
        begin
          if (bit_cnt == DATA_LAST)
          begin
            next_wr_en   = !is_read; // [RULE_13]
            next_state   = FRAME_HUNT;
            next_bit_cnt = 5'h00;
          end
          else
            next_bit_cnt = bit_cnt + 5'h01;
        end
        FRAME_SKIP:
        begin
          // Rest of a foreign or malformed frame passes unseen
          if (bit_cnt == 5'h01)
          begin
            next_state   = FRAME_HUNT; // [RULE_14]
            next_bit_cnt = 5'h00;
          end
          else
            next_bit_cnt = bit_cnt - 5'h01;
        end
        default:
        begin
          next_state   = FRAME_HUNT;
          next_bit_cnt = 5'h00;
        end
      endcase
    end
  end

  // Frame decoder registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= FRAME_HUNT;
      bit_cnt  <= 5'h00;
      is_read  <= 1'b0;
      channel  <= 2'h0;
      reg_addr <= 5'h00;
    end
    else
    begin
      state    <= next_state;
      bit_cnt  <= next_bit_cnt;
      is_read  <= next_is_read;
      channel  <= next_channel;
      reg_addr <= next_reg_addr;
    end
  end

  // Incoming bit shifter, most significant bit first
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_shift <= 16'h0000;
    else if (mdc_rise)
      rx_shift <= shifted; // [RULE_13]
  end

  // One-cycle access strobes toward the register bank
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bank_bus.rd_en   <= 1'b0;
      bank_bus.wr_en   <= 1'b0;
      bank_bus.wr_data <= 16'h0000;
    end
    else
    begin
      bank_bus.rd_en <= next_rd_en;
      bank_bus.wr_en <= next_wr_en; // [RULE_05]
      if (next_wr_en)
        bank_bus.wr_data <= shifted;
    end
  end

  // Address lines follow the decoded fields
  assign bank_bus.channel  = channel; // [RULE_15]
  assign bank_bus.reg_addr = reg_addr;

  mgmt_register_bank bank_inst (
    .clk   (core_clk),
    .rst_n (rst_n),
    .bus   (bank_bus)
  );

  // Rises that close each read bit time
  assign ta_first_end  = mdc_rise && (state == FRAME_TA) && (bit_cnt == 5'h00);
  assign ta_second_end = mdc_rise && (state == FRAME_TA) && (bit_cnt == TA_LAST);
  assign data_bit_end  = mdc_rise && (state == FRAME_DATA) && (bit_cnt != DATA_LAST);
  assign data_last_end = mdc_rise && (state == FRAME_DATA) && (bit_cnt == DATA_LAST);

  // Read drive: float first turnaround, zero second, then data bits
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      tx_shift <= 16'h0000;
    end
    else if (ta_first_end)
    begin
      mdio_out <= 1'b0; // [RULE_12]
      mdio_oe  <= is_read;
      tx_shift <= bank_bus.rd_data;
    end
    // Writes never shift a bit out, so a released line keeps its output low
    else if ((ta_second_end || data_bit_end) && is_read)
    begin
      mdio_out <= tx_shift[15]; // [RULE_13] [RULE_18] [RULE_20]
      tx_shift <= {tx_shift[14:0], 1'b0};
    end
    else if (data_last_end || (state != FRAME_TA && state != FRAME_DATA))
    begin
      mdio_out <= 1'b0; // [RULE_20]
      mdio_oe  <= 1'b0;
    end
  end

endmodule

// ===== hw/mgmt_pkg.sv
// Notes on behaviour
// RULE_01: Management clock from the controller stays at or below 12.5 MHz.
// RULE_02: A full frame opens with thirty-two ones before the start pattern.
// RULE_03: Frames without preamble are accepted; status bit 6 reads one.
// RULE_04: Start pattern 01 must be seen before the frame is decoded.
// RULE_05: Operation 10 reads a register, 01 writes one.
// RULE_06: Five-bit PHY address follows the operation, most significant bit first.
// RULE_07: All-zero PHY address is broadcast and always matches.
// RULE_08: Upper three PHY address bits are compared with the chip address straps.
// RULE_09: Lower two PHY address bits pick channel A, B, C or D.
// RULE_10: Five-bit register address follows, most significant bit first, thirty-two registers.
// RULE_11: On writes the controller drives turnaround as one then zero.
// RULE_12: On reads the device floats turnaround bit one and drives bit two low.
// RULE_13: Sixteen data bits travel from bit 15 down to bit 0.
// RULE_14: The controller sends each access as one uninterrupted frame.
// RULE_15: Four independent register copies exist, one per channel.
// RULE_16: Registers are sixteen bits and return to their listed reset values.
// RULE_17: Soft reset bit in any channel resets all channels, then clears itself.
// RULE_18: Data line sampled on clock rise; driven bits change just after a rise.
// RULE_19: Frames for other chip addresses are ignored and the line stays released.
// RULE_20: Outside read turnaround and data the data line stays released.
package mgmt_pkg;

  // Input pipeline and strap capture
  localparam int         SYNC_WIDTH          = 5;
  localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h8;

  // Frame field codes and lengths
  localparam logic [1:0] OP_READ         = 2'h2;
  localparam logic [1:0] OP_WRITE        = 2'h1;
  localparam logic [4:0] BROADCAST_ADDR  = 5'h00;
  localparam logic [4:0] OP_LAST         = 5'h01;
  localparam logic [4:0] ADDR_LAST       = 5'h04;
  localparam logic [4:0] TA_LAST         = 5'h01;
  localparam logic [4:0] DATA_LAST       = 5'h0F;
  localparam logic [4:0] SKIP_AFTER_OP   = 5'h1C;
  localparam logic [4:0] SKIP_AFTER_PHY  = 5'h17;

  // Register offsets
  localparam logic [4:0] REG_PHY_CONTROL   = 5'h00;
  localparam logic [4:0] REG_PHY_STATUS    = 5'h01;
  localparam logic [4:0] REG_IDENT_HIGH    = 5'h02;
  localparam logic [4:0] REG_IDENT_LOW     = 5'h03;
  localparam logic [4:0] REG_ADVERTISE     = 5'h04;
  localparam logic [4:0] REG_PARTNER       = 5'h05;
  localparam logic [4:0] REG_EXPANSION     = 5'h06;
  localparam logic [4:0] REG_NEXT_PAGE     = 5'h07;
  localparam logic [4:0] REG_DEVICE_STATUS = 5'h1C;
  localparam logic [4:0] REG_FAST_MODE     = 5'h1D;
  localparam logic [4:0] REG_SLOW_MODE     = 5'h1E;
  localparam logic [4:0] REG_QUICK_STATUS  = 5'h1F;

  // Reset values and field positions
  localparam logic [15:0] PHY_STATUS_VALUE    = 16'h7849;
  localparam int          STATUS_NO_PREAMBLE  = 6;
  localparam int          CONTROL_SOFT_RESET  = 15;
  localparam logic [15:0] READ_ZERO           = 16'h0000;

  // Stored registers per channel, in slot order
  localparam int          CHANNELS     = 4;
  localparam int          STORED_REGS  = 5;
  localparam logic [2:0]  SLOT_CONTROL = 3'h0;
  localparam logic [2:0]  SLOT_ADVERT  = 3'h1;
  localparam logic [2:0]  SLOT_NEXTPG  = 3'h2;
  localparam logic [2:0]  SLOT_FAST    = 3'h3;
  localparam logic [2:0]  SLOT_SLOW    = 3'h4;
  localparam logic [2:0]  SLOT_NONE    = 3'h7;
  localparam logic [15:0] SLOT_DEFAULT [0:4] =
    '{16'h3000, 16'h01E1, 16'h0000, 16'h1080, 16'h0000};
  localparam logic [15:0] SLOT_WRITE_MASK [0:4] =
    '{16'h7D80, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

  typedef enum logic [2:0] {
    FRAME_HUNT  = 3'h0,
    FRAME_START = 3'h1,
    FRAME_OP    = 3'h2,
    FRAME_PHYAD = 3'h3,
    FRAME_REGAD = 3'h4,
    FRAME_TA    = 3'h5,
    FRAME_DATA  = 3'h6,
    FRAME_SKIP  = 3'h7
  } frame_state_t;

endpackage

// ===== hw/mgmt_bank_if.sv
// Access strobes between frame decoder and register bank
interface mgmt_bank_if;
  logic        wr_en;
  logic        rd_en;
  logic [1:0]  channel;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  modport frame (output wr_en, output rd_en, output channel, output reg_addr,
                 output wr_data, input rd_data);
  modport bank  (input wr_en, input rd_en, input channel, input reg_addr,
                 input wr_data, output rd_data);
endinterface

// ===== hw/mgmt_input_sync.sv
module mgmt_input_sync
  import mgmt_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_sync_out;

  // Output follows only where second and third stages agree
  assign next_sync_out = (stage2 & stage3) | (sync_out & (stage2 ^ stage3));

  // Three-stage pipeline
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      stage2   <= stage1;
      stage3   <= stage2;
      sync_out <= next_sync_out;
    end
  end

endmodule

// ===== hw/mgmt_register_bank.sv
module mgmt_register_bank
  import mgmt_pkg::*;
#(
  parameter logic [15:0] IDENT_HIGH = 16'h0A5A, // Arbitrary identity value
  parameter logic [15:0] IDENT_LOW  = 16'h5A00  // Arbitrary identity value
)
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  mgmt_bank_if.bank  bus
);

  logic [15:0] store [0:CHANNELS-1][0:STORED_REGS-1];
  wire  [2:0]  slot;
  wire         is_stored;
  wire         soft_reset;
  wire  [15:0] fixed_value;
  wire  [15:0] read_value;

  // Register offset to storage slot
  assign slot = (bus.reg_addr == REG_PHY_CONTROL) ? SLOT_CONTROL :
                (bus.reg_addr == REG_ADVERTISE)   ? SLOT_ADVERT  :
                (bus.reg_addr == REG_NEXT_PAGE)   ? SLOT_NEXTPG  :
                (bus.reg_addr == REG_FAST_MODE)   ? SLOT_FAST    :
                (bus.reg_addr == REG_SLOW_MODE)   ? SLOT_SLOW    : SLOT_NONE;
  assign is_stored  = (slot != SLOT_NONE);
  assign soft_reset = bus.wr_en && (slot == SLOT_CONTROL)
                      && bus.wr_data[CONTROL_SOFT_RESET]; // [RULE_17]

  // Read-only and reserved registers
  assign fixed_value = (bus.reg_addr == REG_PHY_STATUS) ? PHY_STATUS_VALUE : // [RULE_03]
                       (bus.reg_addr == REG_IDENT_HIGH) ? IDENT_HIGH :
                       (bus.reg_addr == REG_IDENT_LOW)  ? IDENT_LOW  : READ_ZERO;
  assign read_value  = is_stored ? store[bus.channel][slot] : fixed_value; // [RULE_15]

  // Per-channel storage with shared soft reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int c = 0; c < CHANNELS; c++)
        for (int s = 0; s < STORED_REGS; s++)
          store[c][s] <= SLOT_DEFAULT[s]; // [RULE_16]
    end
    else if (soft_reset)
    begin
      for (int c = 0; c < CHANNELS; c++)
        for (int s = 0; s < STORED_REGS; s++)
          store[c][s] <= SLOT_DEFAULT[s]; // [RULE_17]
    end
    else if (bus.wr_en && is_stored)
    begin
      store[bus.channel][slot] <= bus.wr_data & SLOT_WRITE_MASK[slot]; // [RULE_15]
    end
  end

  // Registered read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.rd_data <= READ_ZERO;
    else if (bus.rd_en)
      bus.rd_data <= read_value; // [RULE_16]
  end

endmodule

// ===== testbench/mgmt_port_monitor.sv
module mgmt_port_monitor (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       mdc,
  input wire logic       mdio_in,
  input wire logic       mdio_out,
  input wire logic       mdio_oe,
  input wire logic [2:0] chip_address_straps
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       mdc_q;
  logic [4:0] rise_count;
  logic [8:0] oe_cycles;
  wire        mdc_rise = mdc && !mdc_q;

  // Pin-side edge finder, counts of clock rises and cycles while driving
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdc_q      <= 1'h0;
      rise_count <= 5'h00;
      oe_cycles  <= 9'h000;
    end
    else
    begin
      mdc_q      <= mdc;
      rise_count <= !mdio_oe ? 5'h00 : rise_count + {4'h0, mdc_rise};
      oe_cycles  <= !mdio_oe ? 9'h000 : oe_cycles + 9'h001;
    end
  end

  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  AST_RELEASED_LOW: assert property (!mdio_oe |-> !mdio_out)
    else $error("data output high while released");
  AST_DRIVE_AFTER_RISE: assert property ($rose(mdio_oe) |-> mdc && $past(mdc, 2))
    else $error("drive started away from a clock rise");
  AST_TURN_LOW: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("second turnaround bit not low");
  AST_BIT_AFTER_RISE: assert property (mdio_oe && $past(mdio_oe) && $changed(mdio_out)
    |-> mdc && $past(mdc, 2))
    else $error("data bit changed away from a clock rise");
  AST_DRIVE_SPAN: assert property ($fell(mdio_oe) |-> rise_count == 5'h11)
    else $error("drive window not seventeen clock rises");
  AST_RELEASE_AFTER_RISE: assert property ($fell(mdio_oe) |-> mdc)
    else $error("release away from a clock rise");
  AST_DRIVE_BOUNDED: assert property (mdio_oe |-> oe_cycles < 9'h118)
    else $error("drive held too long");
  AST_QUIET_AFTER_RESET: assert property ($rose(resetn) |-> !mdio_oe [*8])
    else $error("drive right after reset");

  // Main scenarios reached
  cover property ($rose(mdio_oe));
  cover property ($fell(mdio_oe));
  cover property (mdio_oe && mdio_out);
endmodule

bind quad_phy_mgmt_serial_port mgmt_port_monitor u_monitor (
  .core_clk(core_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .chip_address_straps(chip_address_straps));

// ===== testbench/mgmt_station_model.sv
module mgmt_station_model
  import mgmt_pkg::*;
(
  output logic      mdc,
  output logic      mdio_in,
  input  wire logic mdio_out,
  input  wire logic mdio_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv_en;
  logic drv_bit;

  // Shared line: contention is unknown, pull-up when nobody drives
  assign mdio_in = (mdio_oe && drv_en) ? 1'hx : mdio_oe ? mdio_out : drv_en ? drv_bit : 1'h1;

  initial
  begin
    mdc = 1'h0;
    drv_en = 1'h0;
    drv_bit = 1'h1;
  end

  // One whole frame; clock stands low between frames
  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] phy,
                       input logic [4:0] ra, input logic [15:0] wdata, output logic [63:0] cap);
    logic [63:0] vec;
    vec = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wdata};
    cap = '1;
    for (int i = pre ? 63 : 31; i >= 0; i--)
    begin
      drv_en = (op != OP_READ) || (i >= 18);
      drv_bit = vec[i];
      #62.5 mdc = 1'h1;
      cap[i] = mdio_in;
      #62.5 mdc = 1'h0;
    end
    drv_en = 1'h0;
  endtask
endmodule

// ===== testbench/quad_phy_mgmt_serial_port_tb_top.sv
module quad_phy_mgmt_serial_port_tb_top
  import mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic pre; logic wr; logic [4:0] phy; logic [4:0] ra; logic [15:0] data;
  } row_t;
  localparam int LIMIT = 80000;
  logic        core_clk = 1'h0;
  logic        resetn = 1'h0;
  logic [2:0]  chip_address_straps = 3'h5;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic [63:0] cap;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  // Ordinary accesses: prefix, write, address, register, data or expected
  row_t rows [26] = '{
    '{1'h1,1'h0,5'h14,5'h00,16'h3000}, '{1'h0,1'h0,5'h14,5'h01,16'h7849},
    '{1'h1,1'h0,5'h15,5'h02,16'h0A5A}, '{1'h0,1'h0,5'h16,5'h03,16'h5A00},
    '{1'h1,1'h0,5'h17,5'h04,16'h01E1}, '{1'h0,1'h0,5'h14,5'h05,16'h0000},
    '{1'h1,1'h0,5'h14,5'h06,16'h0000}, '{1'h0,1'h0,5'h14,5'h07,16'h0000},
    '{1'h0,1'h0,5'h15,5'h08,16'h0000}, '{1'h1,1'h0,5'h15,5'h1B,16'h0000},
    '{1'h1,1'h0,5'h16,5'h1C,16'h0000}, '{1'h1,1'h0,5'h17,5'h1D,16'h1080},
    '{1'h0,1'h0,5'h17,5'h1E,16'h0000}, '{1'h1,1'h0,5'h14,5'h1F,16'h0000},
    '{1'h1,1'h1,5'h15,5'h04,16'h1234}, '{1'h0,1'h0,5'h15,5'h04,16'h1234},
    '{1'h1,1'h0,5'h14,5'h04,16'h01E1}, '{1'h0,1'h1,5'h16,5'h1D,16'hA5C3},
    '{1'h1,1'h0,5'h00,5'h1D,16'h1080}, '{1'h0,1'h0,5'h16,5'h1D,16'hA5C3},
    '{1'h1,1'h1,5'h17,5'h00,16'h7FFF}, '{1'h1,1'h0,5'h17,5'h00,16'h7D80},
    '{1'h1,1'h1,5'h14,5'h01,16'h0000}, '{1'h1,1'h0,5'h14,5'h01,16'h7849},
    '{1'h1,1'h1,5'h00,5'h07,16'hBEEF}, '{1'h1,1'h0,5'h14,5'h07,16'hBEEF}};

  quad_phy_mgmt_serial_port uut (
    .core_clk(core_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .chip_address_straps(chip_address_straps));
  mgmt_station_model u_station (
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));

  always #4 core_clk = ~core_clk;

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic pre, input logic [4:0] phy, ra, input logic [15:0] exp);
    u_station.frame(pre, OP_READ, phy, ra, 16'h0000, cap);
    check(cap[15:0], exp);
    check({14'h0000, cap[17:16]}, 16'h0002);
  endtask

  task automatic wr(input logic pre, input logic [4:0] phy, ra, input logic [15:0] data);
    u_station.frame(pre, OP_WRITE, phy, ra, data, cap);
    check(cap[15:0], data);
    check({14'h0000, cap[17:16]}, 16'h0002);
  endtask

  // Read that nobody should answer: line stays at the pull-up
  task automatic miss(input logic [4:0] phy);
    u_station.frame(1'h0, OP_READ, phy, 5'h01, 16'h0000, cap);
    check(cap[15:0], 16'hFFFF);
    check({14'h0000, cap[17:16]}, 16'h0003);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  initial
  begin
    repeat (5) @(negedge core_clk);
    resetn = 1'h1;
    repeat (25) @(negedge core_clk);
    foreach (rows[i])
    begin
      if (rows[i].wr)
        wr(rows[i].pre, rows[i].phy, rows[i].ra, rows[i].data);
      else
        rd(rows[i].pre, rows[i].phy, rows[i].ra, rows[i].data);
    end
    done("rows");
    miss(5'h08);
    wr(1'h1, 5'h0C, 5'h04, 16'h5555);
    rd(1'h0, 5'h14, 5'h04, 16'h01E1);
    done("address miss");
    u_station.frame(1'h1, 2'h3, 5'h14, 5'h04, 16'h0F0F, cap);
    u_station.frame(1'h0, 2'h0, 5'h14, 5'h04, 16'h0F0F, cap);
    rd(1'h0, 5'h14, 5'h04, 16'h01E1);
    done("undefined op");
    wr(1'h1, 5'h15, 5'h00, 16'h8000);
    rd(1'h1, 5'h15, 5'h04, 16'h01E1);
    rd(1'h1, 5'h16, 5'h1D, 16'h1080);
    rd(1'h1, 5'h15, 5'h00, 16'h3000);
    done("soft reset");
    wr(1'h1, 5'h14, 5'h1E, 16'h00FF);
    @(negedge core_clk);
    resetn = 1'h0;
    chip_address_straps = 3'h3;
    repeat (5) @(negedge core_clk);
    resetn = 1'h1;
    repeat (25) @(negedge core_clk);
    rd(1'h1, 5'h0C, 5'h1E, 16'h0000);
    miss(5'h14);
    done("hard reset");
    summarize();
  end
endmodule
